// *** verilog/rtcp_pkg.sv ***
/*
 * rtcp_pkg: shared constants, register layout and types for the
 * multifunction pin and oscillator trim block.
 * Assumes one core clock; the oscillator arrives as a sampled pin level.
 */
`default_nettype none

package rtcp_pkg;

    // register offsets on the register port
    localparam logic [7:0] RTC_OUTPUT_CONTROL_ADDR = 8'h07;
    localparam logic [7:0] OSCILLATOR_TRIM_ADDR    = 8'h08;

    // reset values: output level bit set, everything else clear
    localparam logic [7:0] RTC_OUTPUT_CONTROL_RESET = 8'h80;
    localparam logic [7:0] OSCILLATOR_TRIM_RESET    = 8'h00;

    // divider chain: 15 bits divides the oscillator by 32768
    localparam int unsigned DIV_WIDTH = 15;
    // taps of the divider chain for each square-wave rate
    localparam int unsigned TAP_8K    = 1;
    localparam int unsigned TAP_4K    = 2;
    localparam int unsigned TAP_64HZ  = 8;
    localparam int unsigned TAP_1HZ   = 14;
    // coarse trim fires on carry out of the low 8 bits: 128 times a second
    localparam int unsigned COARSE_WIDTH = 8;
    localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;

    // trim magnitude width and pending-cycle width (twice the magnitude)
    localparam int unsigned TRIM_WIDTH = 7;
    localparam int unsigned PEND_WIDTH = 8;

    typedef struct packed {
        logic       out_level;
        logic       square_output_enable;
        logic       alarm_one_enable;
        logic       alarm_zero_enable;
        logic       external_clock_enable;
        logic       coarse_trim_enable;
        logic [1:0] square_rate_select;
    } rtcp_control_s;

    typedef struct packed {
        logic                  add_cycles;
        logic [TRIM_WIDTH-1:0] trim_magnitude;
    } rtcp_trim_s;

    typedef enum logic [1:0] {
        RATE_1HZ  = 2'b00,
        RATE_4K   = 2'b01,
        RATE_8K   = 2'b10,
        RATE_PASS = 2'b11
    } rtcp_rate_e;

    typedef enum logic [1:0] {
        MODE_GPO    = 2'b00,
        MODE_ALARM  = 2'b01,
        MODE_SQUARE = 2'b10
    } rtcp_mode_e;

    typedef enum logic [0:0] {
        TRIM_IDLE   = 1'b0,
        TRIM_ACTIVE = 1'b1
    } rtcp_trim_state_e;

endpackage

`default_nettype wire

// *** verilog/rtcp_trim_chain.sv ***
/*
 * rtcp_trim_chain: oscillator divider chain with digital trim.
 * Assumes osc_tick is a one-cycle pulse per oscillator cycle on core_clk.
 */
`default_nettype none

module rtcp_trim_chain
    import rtcp_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 osc_tick,
    input  wire logic                 coarse_trim_enable,
    input  wire rtcp_trim_s           trim,
    output logic     [DIV_WIDTH-1:0]  div_count,
    output logic                      second_pulse,
    output logic                      trim_busy
);

    rtcp_trim_state_e        state;
    rtcp_trim_state_e        next_state;
    logic [PEND_WIDTH-1:0]   pend;
    logic [PEND_WIDTH-1:0]   next_pend;
    logic                    dir_add;
    logic                    next_dir_add;
    logic [DIV_WIDTH-1:0]    next_div_count;
    logic [5:0]              sec_count;
    logic [5:0]              next_sec_count;
    logic                    next_second_pulse;
    logic [1:0]              inc;
    logic [DIV_WIDTH:0]      full_sum;
    logic [COARSE_WIDTH:0]   low_sum;
    logic                    sec_carry;
    logic                    coarse_carry;
    logic                    minute_carry;
    logic                    trigger;

    always_comb begin
        next_state        = state;
        next_pend         = pend;
        next_dir_add      = dir_add;
        next_sec_count    = sec_count;
        next_second_pulse = 1'b0;
        inc               = 2'h1;
        // an active trim step adds an extra count or swallows this one
        if (state == TRIM_ACTIVE && pend != '0) begin
            inc = dir_add ? 2'h2 : 2'h0; // R11
        end
        full_sum     = {1'b0, div_count} + {{(DIV_WIDTH-1){1'b0}}, inc};
        low_sum      = {1'b0, div_count[COARSE_WIDTH-1:0]} + {{(COARSE_WIDTH-1){1'b0}}, inc};
        sec_carry    = osc_tick & full_sum[DIV_WIDTH];
        coarse_carry = osc_tick & low_sum[COARSE_WIDTH];
        minute_carry = sec_carry && (sec_count == SECONDS_PER_MINUTE - 6'h01);
        next_div_count = osc_tick ? full_sum[DIV_WIDTH-1:0] : div_count; // R18
        if (sec_carry) begin
            next_second_pulse = 1'b1;
            next_sec_count    = minute_carry ? 6'h00 : sec_count + 6'h01;
        end
        if (osc_tick && state == TRIM_ACTIVE) begin
            if (pend <= 8'h01) begin
                next_pend  = '0;
                next_state = TRIM_IDLE;
            end else begin
                next_pend = pend - 8'h01;
            end
        end
        trigger = coarse_trim_enable ? coarse_carry : minute_carry; // R10 R15
        if (trigger && trim.trim_magnitude != '0) begin // R13
            next_pend    = {trim.trim_magnitude, 1'b0}; // R12
            next_dir_add = trim.add_cycles; // R11
            next_state   = TRIM_ACTIVE;
        end
        case (state)
            TRIM_IDLE:   trim_busy = 1'b0;
            TRIM_ACTIVE: trim_busy = 1'b1;
            default:     trim_busy = 1'b0;
        endcase
    end

    // trim keeps running regardless of supply source
    always_ff @(posedge core_clk) begin // R14
        if (rst) begin
            state        <= TRIM_IDLE;
            pend         <= '0;
            dir_add      <= 1'b0;
            div_count    <= '0;
            sec_count    <= 6'h00;
            second_pulse <= 1'b0;
        end else begin
            state        <= next_state;
            pend         <= next_pend;
            dir_add      <= next_dir_add;
            div_count    <= next_div_count;
            sec_count    <= next_sec_count;
            second_pulse <= next_second_pulse;
        end
    end

endmodule

`default_nettype wire

// *** verilog/rtcp_mfp_trim.sv ***
/*
 * rtcp_mfp_trim: multifunction open-drain pin and oscillator trim.
 * Assumes alarm flags, polarity and the oscillator run bit come from
 * core_clk logic; oscillator and external clock arrive as pin levels.
 */
// What this block does
// R1 - square rate field picks postscaler 1:32768, 1:8, 1:4 or 1:1
// R2 - no square-wave clock on the pin while on backup supply
// R3 - divided rates carry trim; the 1:1 pass-through does not
// R4 - square off and an alarm enabled: pin shows alarm interrupt
// R5 - alarm interrupt output keeps working on backup supply
// R6 - one alarm: pin is its flag, inverted when polarity is zero
// R7 - two alarms: OR when polarity one, inverted AND when zero
// R8 - square and alarms off: pin follows the output-level bit
// R9 - no general-purpose level on the pin while on backup supply
// R10 - coarse off: one trim adjustment per minute
// R11 - sign bit one adds cycles, zero subtracts cycles
// R12 - each adjustment is twice the seven-bit magnitude, up to 254
// R13 - zero magnitude means no trim adjustment
// R14 - trim continues while running from backup supply
// R15 - coarse on: adjustment applied 128 times per second
// R16 - host zeroes trim, starts clock, picks rate, enables square before measuring
// R17 - coarse and square on: trimmed 64 Hz on the pin regardless of rate
// R18 - trim acts on the divider feeding seconds and the postscaler
`default_nettype none

module rtcp_mfp_trim
    import rtcp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reg_sel,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        osc_in,
    input  wire logic        ext_clk_in,
    input  wire logic        oscillator_run_bit,
    input  wire logic        on_backup,
    input  wire logic        alarm_zero_flag,
    input  wire logic        alarm_one_flag,
    input  wire logic        alarm_pin_polarity,
    input  wire logic        multifunction_pin_in,
    output logic             multifunction_pin_out,
    output logic             multifunction_pin_oe_n,
    output logic             second_pulse,
    output logic             trim_busy
);

    localparam int unsigned SYNC_LANES = 2;

    rtcp_control_s           control;
    rtcp_control_s           next_control;
    rtcp_trim_s              trim;
    rtcp_trim_s              next_trim;
    logic [7:0]              next_reg_rdata;
    logic [SYNC_LANES-1:0]   sync_in;
    logic [SYNC_LANES-1:0]   sync_meta;
    logic [SYNC_LANES-1:0]   sync_q;
    logic [SYNC_LANES-1:0]   sync_prev;
    logic                    src_level;
    logic                    src_prev;
    logic                    running;
    logic                    osc_tick;
    logic [DIV_WIDTH-1:0]    div_count;
    logic                    square_level;
    logic                    alarm_level;
    rtcp_mode_e              mode;
    logic                    pin_level;
    logic                    next_pin_level;
    logic                    pin_seen;
    logic                    pin_meta;

    // register port: writes and reads happen only while on primary supply
    always_comb begin
        next_control   = control;
        next_trim      = trim;
        next_reg_rdata = 8'h00;
        if (reg_sel && !on_backup) begin
            if (reg_write) begin
                case (reg_addr)
                    RTC_OUTPUT_CONTROL_ADDR: next_control = rtcp_control_s'(reg_wdata);
                    OSCILLATOR_TRIM_ADDR:    next_trim    = rtcp_trim_s'(reg_wdata);
                    default:                 next_control = control;
                endcase
            end else begin
                case (reg_addr)
                    RTC_OUTPUT_CONTROL_ADDR: next_reg_rdata = control;
                    OSCILLATOR_TRIM_ADDR:    next_reg_rdata = trim;
                    default:                 next_reg_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            control   <= rtcp_control_s'(RTC_OUTPUT_CONTROL_RESET);
            trim      <= rtcp_trim_s'(OSCILLATOR_TRIM_RESET);
            reg_rdata <= 8'h00;
        end else begin
            control   <= next_control;
            trim      <= next_trim;
            reg_rdata <= next_reg_rdata;
        end
    end

    // two-flop synchronisers for the crystal and external clock pins
    assign sync_in = {ext_clk_in, osc_in};

    genvar lane;
    generate
        for (lane = 0; lane < SYNC_LANES; lane++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    sync_meta[lane] <= 1'b0;
                    sync_q[lane]    <= 1'b0;
                    sync_prev[lane] <= 1'b0;
                end else begin
                    sync_meta[lane] <= sync_in[lane];
                    sync_q[lane]    <= sync_meta[lane];
                    sync_prev[lane] <= sync_q[lane];
                end
            end
        end
    endgenerate

    // pick the clock source; the external input also counts as running
    always_comb begin
        src_level = control.external_clock_enable ? sync_q[1] : sync_q[0];
        src_prev  = control.external_clock_enable ? sync_prev[1] : sync_prev[0];
        running   = control.external_clock_enable | oscillator_run_bit;
        osc_tick  = running & src_level & ~src_prev;
    end

    rtcp_trim_chain u_trim_chain (
        .core_clk           (core_clk),
        .rst                (rst),
        .osc_tick           (osc_tick),
        .coarse_trim_enable (control.coarse_trim_enable),
        .trim               (trim),
        .div_count          (div_count),
        .second_pulse       (second_pulse),
        .trim_busy          (trim_busy)
    );

    // postscaler taps come from the trimmed chain; pass-through bypasses it
    always_comb begin
        if (control.coarse_trim_enable) begin
            square_level = div_count[TAP_64HZ]; // R17
        end else begin
            case (rtcp_rate_e'(control.square_rate_select)) // R1
                RATE_1HZ:  square_level = div_count[TAP_1HZ]; // R3
                RATE_4K:   square_level = div_count[TAP_4K]; // R3
                RATE_8K:   square_level = div_count[TAP_8K]; // R3
                RATE_PASS: square_level = src_level & running; // R3
                default:   square_level = 1'b1;
            endcase
        end
    end

    // alarm interrupt combination under the polarity setting
    always_comb begin
        case ({control.alarm_one_enable, control.alarm_zero_enable})
            2'b01:   alarm_level = ~(alarm_zero_flag ^ alarm_pin_polarity); // R6
            2'b10:   alarm_level = ~(alarm_one_flag ^ alarm_pin_polarity); // R6
            2'b11:   alarm_level = alarm_pin_polarity ?
                                   (alarm_zero_flag | alarm_one_flag) :
                                   ~(alarm_zero_flag & alarm_one_flag); // R7
            default: alarm_level = 1'b1;
        endcase
    end

    // pin mode and level; a high level releases the open-drain pin
    always_comb begin
        if (control.square_output_enable) begin
            mode = MODE_SQUARE;
        end else if (control.alarm_zero_enable | control.alarm_one_enable) begin
            mode = MODE_ALARM; // R4
        end else begin
            mode = MODE_GPO;
        end
        case (mode)
            MODE_SQUARE: next_pin_level = on_backup ? 1'b1 : square_level; // R2
            MODE_ALARM:  next_pin_level = alarm_level; // R5
            MODE_GPO:    next_pin_level = on_backup ? 1'b1 : control.out_level; // R8 R9
            default:     next_pin_level = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_level <= 1'b1;
            pin_meta  <= 1'b1;
            pin_seen  <= 1'b1;
        end else begin
            pin_level <= next_pin_level;
            pin_meta  <= multifunction_pin_in;
            pin_seen  <= pin_meta;
        end
    end

    // open drain: only ever pull low; enable is active low when driving
    assign multifunction_pin_out  = 1'b0;
    assign multifunction_pin_oe_n = pin_level;

endmodule

`default_nettype wire

// *** verification/rtcp_host_model.sv ***
/* rtcp_host_model: host side of the open-drain pin, with its pull-up.
   Assumes the block only pulls low; a released line reads high. */
`default_nettype none
module rtcp_host_model (
    input  wire logic multifunction_pin_out,
    input  wire logic multifunction_pin_oe_n,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up wins whenever the block lets go
    assign pin_level = multifunction_pin_oe_n ? 1'b1 : multifunction_pin_out;
endmodule
`default_nettype wire

// *** verification/rtcp_mfp_trim_chk.sv ***
/* rtcp_mfp_trim_chk: port checks of the pin and register port.
   Assumes a bind onto rtcp_mfp_trim; keeps its own copy of control. */
`default_nettype none
module rtcp_mfp_trim_chk
    import rtcp_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       reg_sel,
    input wire logic       reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       on_backup,
    input wire logic       alarm_zero_flag,
    input wire logic       alarm_one_flag,
    input wire logic       alarm_pin_polarity,
    input wire logic       multifunction_pin_out,
    input wire logic       multifunction_pin_oe_n,
    input wire logic       second_pulse,
    input wire logic       trim_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    rtcp_control_s ctl;
    rtcp_control_s next_ctl;
    logic          rd_ok;
    logic          gpo;
    logic          alm;
    logic          one;
    logic          lvl;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    assign rd_ok = reg_sel && !reg_write && !on_backup;
    assign gpo = !ctl.square_output_enable && !ctl.alarm_zero_enable && !ctl.alarm_one_enable;
    assign alm = !ctl.square_output_enable && !gpo;
    assign one = ctl.alarm_zero_enable ^ ctl.alarm_one_enable;
    assign lvl = one ? ((ctl.alarm_zero_enable ? alarm_zero_flag : alarm_one_flag)
                 ~^ alarm_pin_polarity) : (alarm_pin_polarity ?
                 (alarm_zero_flag | alarm_one_flag) : ~(alarm_zero_flag & alarm_one_flag));
    always_comb begin
        next_ctl = ctl;
        if (rst) begin
            next_ctl = rtcp_control_s'(RTC_OUTPUT_CONTROL_RESET);
        end else if (reg_sel && reg_write && !on_backup
                     && reg_addr == RTC_OUTPUT_CONTROL_ADDR) begin
            next_ctl = rtcp_control_s'(reg_wdata);
        end
    end
    always_ff @(posedge core_clk) begin
        ctl <= next_ctl;
    end
    a_drain_low: assert property (!multifunction_pin_out)
        else $error("pin driven high");
    a_gpo_level: assert property (gpo && !on_backup ##1 gpo && !on_backup
        |-> multifunction_pin_oe_n == $past(ctl.out_level)) else $error("gpo level wrong");
    a_gpo_backup: assert property (gpo && on_backup |=> multifunction_pin_oe_n)
        else $error("gpo driven on backup");
    a_square_backup: assert property (ctl.square_output_enable && on_backup
        |=> multifunction_pin_oe_n) else $error("square driven on backup");
    a_one_alarm: assert property (alm && one |=> multifunction_pin_oe_n == $past(lvl))
        else $error("single alarm level wrong");
    a_two_alarms: assert property (alm && !one |=> multifunction_pin_oe_n == $past(lvl))
        else $error("dual alarm level wrong");
    a_reset_release: assert property ($past(rst) |-> multifunction_pin_oe_n
        && reg_rdata == 8'h00 && !trim_busy && !second_pulse) else $error("reset state wrong");
    a_read_ctl: assert property (rd_ok && reg_addr == RTC_OUTPUT_CONTROL_ADDR
        |=> reg_rdata == $past(ctl)) else $error("control readback wrong");
    a_rdata_idle: assert property (!$past(rd_ok) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_pulse_single: assert property (second_pulse |=> !second_pulse)
        else $error("second pulse too long");
    c_gpo_low: cover property (gpo && !multifunction_pin_oe_n);
    c_alarm_low: cover property (alm && !multifunction_pin_oe_n);
    c_read: cover property (rd_ok);
    c_trim_busy: cover property (trim_busy);
endmodule
`default_nettype wire

// *** verification/tb_rtcp_mfp_trim.sv ***
/* tb_rtcp_mfp_trim: self-checking bench of the pin modes and trim.
   Assumes a 250 MHz core clock; oscillator period 4, external 8 cycles. */
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb_rtcp_mfp_trim
    import rtcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk   = 1'b0;
    logic       rst        = 1'b1;
    logic       reg_sel    = 1'b0;
    logic       reg_write  = 1'b0;
    logic [7:0] reg_addr   = 8'h00;
    logic [7:0] reg_wdata  = 8'h00;
    logic       osc_in     = 1'b0;
    logic       ext_clk_in = 1'b0;
    logic       on_backup  = 1'b0;
    logic       f0         = 1'b0;
    logic       f1         = 1'b0;
    logic       pol        = 1'b0;
    logic [2:0] ocnt       = 3'h0;
    logic [7:0] reg_rdata;
    logic [7:0] rd;
    logic       pin_out;
    logic       oe_n;
    logic       busy;
    logic       pin;
    logic       want;
    int         fail_count = 0;
    int         n_tests    = 0;
    int         n;
    logic [7:0] row_ctl [8] = '{8'h42, 8'h41, 8'h43, 8'h4A, 8'h47, 8'h47, 8'h47, 8'h47};
    logic [7:0] row_trim[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h10, 8'h7F};
    int         row_half[8] = '{8, 16, 2, 16, 1024, 896, 1152, 2040};
    rtcp_mfp_trim rtcp_mfp_trim_i (.core_clk(core_clk), .rst(rst), .reg_sel(reg_sel),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .osc_in(osc_in), .ext_clk_in(ext_clk_in),
        .oscillator_run_bit(1'b1), .on_backup(on_backup), .alarm_zero_flag(f0),
        .alarm_one_flag(f1), .alarm_pin_polarity(pol), .multifunction_pin_in(pin),
        .multifunction_pin_out(pin_out), .multifunction_pin_oe_n(oe_n),
        .second_pulse(), .trim_busy(busy));
    rtcp_host_model rtcp_host_model_i (.multifunction_pin_out(pin_out),
        .multifunction_pin_oe_n(oe_n), .pin_level(pin));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        ocnt <= ocnt + 3'h1;
        osc_in <= ocnt[1];
        ext_clk_in <= ocnt[2];
    end
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_sel <= 1'b1;
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_sel <= 1'b0;
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_sel <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_sel <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic half_period(output int h);
        logic l;
        int   k;
        @(negedge core_clk);
        l = pin;
        k = 0;
        while (pin === l && k < 5000) begin
            @(negedge core_clk);
            k++;
        end
        l = pin;
        h = 0;
        while (pin === l && h < 5000) begin
            @(negedge core_clk);
            h++;
        end
    endtask
    // which = 0 counts low pin cycles, which = 1 counts busy cycles
    task automatic count_cyc(input int cycles, input logic which, output int c);
        c = 0;
        repeat (cycles) begin
            @(negedge core_clk);
            c += which ? int'(busy === 1'b1) : int'(pin !== 1'b1);
        end
    endtask
    task automatic set_backup(input logic b);
        @(posedge core_clk);
        on_backup <= b;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            reg_wr(OSCILLATOR_TRIM_ADDR, row_trim[i]);
            reg_wr(RTC_OUTPUT_CONTROL_ADDR, row_ctl[i]);
            repeat (3) half_period(n);
            `CHK(n, row_half[i])
        end
        $display("test rates done");
        for (int e = 1; e < 4; e++) begin
            reg_wr(RTC_OUTPUT_CONTROL_ADDR, {2'b00, e[1:0], 4'h0});
            for (int i = 0; i < 8; i++) begin
                @(posedge core_clk);
                {pol, f1, f0} <= i[2:0];
                on_backup <= i[1];
                repeat (2) @(posedge core_clk);
                @(negedge core_clk);
                want = (e == 3) ? (pol ? (f0 | f1) : ~(f0 & f1)) : ((e == 1 ? f0 : f1) ~^ pol);
                `CHK(pin, want)
            end
            set_backup(1'b0);
        end
        $display("test alarms done");
        reg_wr(RTC_OUTPUT_CONTROL_ADDR, 8'h00);
        count_cyc(3, 1'b0, n);
        `CHK(pin, 1'b0)
        set_backup(1'b1);
        reg_wr(RTC_OUTPUT_CONTROL_ADDR, 8'h80);
        @(negedge core_clk);
        `CHK(pin, 1'b1)
        set_backup(1'b0);
        reg_rd(RTC_OUTPUT_CONTROL_ADDR, rd);
        `CHK(rd, 8'h00)
        reg_wr(RTC_OUTPUT_CONTROL_ADDR, 8'h43);
        set_backup(1'b1);
        count_cyc(3, 1'b0, n);
        count_cyc(40, 1'b0, n);
        `CHK(n, 0)
        set_backup(1'b0);
        reg_wr(OSCILLATOR_TRIM_ADDR, 8'h00);
        reg_wr(RTC_OUTPUT_CONTROL_ADDR, 8'h04);
        set_backup(1'b1);
        count_cyc(1100, 1'b1, n);
        count_cyc(1100, 1'b1, n);
        `CHK(n, 0)
        set_backup(1'b0);
        reg_wr(OSCILLATOR_TRIM_ADDR, 8'h10);
        set_backup(1'b1);
        count_cyc(1100, 1'b1, n);
        `CHK(n > 0, 1'b1)
        $display("test backup and trim done");
        set_backup(1'b0);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        reg_rd(RTC_OUTPUT_CONTROL_ADDR, rd);
        `CHK(rd, RTC_OUTPUT_CONTROL_RESET)
        reg_rd(OSCILLATOR_TRIM_ADDR, rd);
        `CHK(rd, OSCILLATOR_TRIM_RESET)
        reg_rd(8'h09, rd);
        `CHK(rd, 8'h00)
        `CHK(pin, 1'b1)
        $display("test reset done");
        report_and_stop();
    end
endmodule
bind rtcp_mfp_trim rtcp_mfp_trim_chk rtcp_mfp_trim_chk_i (.core_clk(core_clk), .rst(rst),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .on_backup(on_backup), .alarm_zero_flag(alarm_zero_flag),
    .alarm_one_flag(alarm_one_flag), .alarm_pin_polarity(alarm_pin_polarity),
    .multifunction_pin_out(multifunction_pin_out),
    .multifunction_pin_oe_n(multifunction_pin_oe_n), .second_pulse(second_pulse),
    .trim_busy(trim_busy));
`default_nettype wire
